/* rtl/rghb_map.vh */
// register map, field positions and reset values for the gain and echo balance bank
`ifndef RGHB_MAP_VH
`define RGHB_MAP_VH
`define RGHB_ADDR_W 8
`define RGHB_OFF_RX_GAIN 8'h00
`define RGHB_OFF_ECHO_CTRL 8'h04
`define RGHB_OFF_SEC1 8'h08
`define RGHB_OFF_SEC2 8'h0C
`define RGHB_OFF_STATUS 8'h10
`define RGHB_OFF_LEVEL 8'h14
`define RGHB_OFF_INFO 8'h18
`define RGHB_RST_RX_GAIN 8'h00
`define RGHB_RST_ECHO_CTRL 8'h00
`define RGHB_RST_SEC1 8'h00
`define RGHB_RST_SEC2 8'h00
`define RGHB_CTRL_EN_BIT 7
`define RGHB_CTRL_NONINV_BIT 6
`define RGHB_CTRL_SEC2_BIT 5
`define RGHB_ATTEN_MSB 4
`define RGHB_ATTEN_MAX 5'h18
`define RGHB_ATTEN_BASE_QDB 8'h0A
`define RGHB_SEC1_MODE_BIT 7
`define RGHB_SEC1_SET_MSB 6
`define RGHB_SEC2_POLE_MSB 7
`define RGHB_SEC2_POLE_LSB 4
`define RGHB_SEC2_ZERO_MSB 3
`define RGHB_GAIN_REF_CODE 9'h0AE
`define RGHB_ST_WRITTEN_LSB 0
`define RGHB_ST_ACTIVE_BIT 3
`define RGHB_ST_MUTED_BIT 4
`define RGHB_ST_CLAMP_BIT 5
`define RGHB_ST_SEC1_BIT 6
`define RGHB_ST_SEC2_BIT 7
`define RGHB_LVL_ATTEN_LSB 16
`define RGHB_REVISION 8'h01
`endif

/* rtl/rghb_avs.v */
// avalon-mm slave front end with one wait cycle per transfer
`timescale 1ns/1ps
`include "rghb_map.vh"
module rghb_avs (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_read,
  input wire i_write,
  input wire [7:0] i_address,
  input wire [3:0] i_byteenable,
  input wire [31:0] i_writedata,
  input wire [31:0] i_rd_value,
  output reg o_waitrequest,
  output reg [31:0] o_readdata,
  output wire [5:0] o_index,
  output wire o_wr_strobe,
  output wire [7:0] o_wr_data
);
  localparam ST_IDLE = 1'b0;
  localparam ST_ANSWER = 1'b1;
  reg state_r;
  reg state_nxt;

  assign o_index = i_address[7:2];
  // the write lands on the edge where the master sees waitrequest low
  assign o_wr_strobe = (state_r == ST_ANSWER) & i_write & i_byteenable[0];
  assign o_wr_data = i_writedata[7:0];

  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = (i_read | i_write) ? ST_ANSWER : ST_IDLE;
      ST_ANSWER: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      o_waitrequest <= ~((state_r == ST_IDLE) & (i_read | i_write));
      if ((state_r == ST_IDLE) & i_read) begin
        o_readdata <= i_rd_value;
      end
    end
  end
endmodule

/* rtl/rghb_cfg.v */
// receive gain and echo balance configuration bank
// Behaviour
// (R1) hold an 8-bit receive gain code; each step is 0.1 dB of output level
// (R2) host computes the gain code from 200*log10(V/sqrt6)+174, rounded
// (R3) either echo filter section can be bypassed on its own
// (R4) control bit 7 clear disables cancellation; set enables the path
// (R5) control bit 6 clear assumes an inverting echo path; set assumes none
// (R6) control bit 5 clear bypasses the high section; set inserts it
// (R7) control bits 4..0 set attenuation, -2.5 dB at 00000 to -8.5 dB at 11000
// (R8) after reset the cancellation filter stays disabled until programmed
// (R9) section one register selects section, mode and setting; all-zero bypasses it
// (R10) first-order mode: one real pole, zero at dc, frequency from setting
// (R11) section two register places pole and zero independently
// (R12) host writes all three balance registers before relying on cancellation
// (R13) every register keeps its last written value until rewritten or reset
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "rghb_map.vh"
module rghb_cfg (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [7:0] i_avs_address,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] i_avs_writedata,
  output wire o_avs_waitrequest,
  output wire [31:0] o_avs_readdata,
  output reg [7:0] o_rx_gain_code,
  output reg o_rx_muted,
  output reg signed [8:0] o_rx_level_tenth_db,
  output reg o_rx_gain_update,
  output reg o_cancel_enable,
  output reg o_cancel_noninvert,
  output reg o_high_freq_section_enable,
  output reg [4:0] o_cancel_attenuation,
  output reg [7:0] o_cancel_atten_quarter_db,
  output reg o_low_freq_section_enable,
  output reg o_low_freq_biquad,
  output reg o_low_freq_zero_at_dc,
  output reg [6:0] o_low_freq_setting,
  output reg [3:0] o_high_freq_pole,
  output reg [3:0] o_high_freq_zero,
  output reg o_balance_update
);
  parameter [7:0] REVISION = `RGHB_REVISION; // arbitrary value

  // word indices; the two low address bits never take part in decoding
  localparam [7:0] OFF_GAIN = `RGHB_OFF_RX_GAIN;
  localparam [7:0] OFF_CTRL = `RGHB_OFF_ECHO_CTRL;
  localparam [7:0] OFF_SEC1 = `RGHB_OFF_SEC1;
  localparam [7:0] OFF_SEC2 = `RGHB_OFF_SEC2;
  localparam [7:0] OFF_STATUS = `RGHB_OFF_STATUS;
  localparam [7:0] OFF_LEVEL = `RGHB_OFF_LEVEL;
  localparam [7:0] OFF_INFO = `RGHB_OFF_INFO;
  localparam [5:0] IX_GAIN = OFF_GAIN[7:2];
  localparam [5:0] IX_CTRL = OFF_CTRL[7:2];
  localparam [5:0] IX_SEC1 = OFF_SEC1[7:2];
  localparam [5:0] IX_SEC2 = OFF_SEC2[7:2];
  localparam [5:0] IX_STATUS = OFF_STATUS[7:2];
  localparam [5:0] IX_LEVEL = OFF_LEVEL[7:2];
  localparam [5:0] IX_INFO = OFF_INFO[7:2];

  wire [5:0] bus_index;
  wire wr_strobe;
  wire [7:0] wr_data;
  reg [31:0] rd_value;

  reg [7:0] receive_gain_r;
  reg [7:0] echo_cancel_control_r;
  reg [7:0] echo_section_one_setting_r;
  reg [7:0] echo_section_two_setting_r;
  reg [2:0] balance_written_r;

  wire wr_gain;
  wire wr_ctrl;
  wire wr_sec1;
  wire wr_sec2;
  wire [2:0] wr_balance;
  wire [4:0] atten_field;
  wire [4:0] atten_clamped;
  wire atten_over;
  wire sec1_selected;
  wire cancel_on;
  wire [8:0] level_diff;
  wire [7:0] atten_qdb;
  reg [7:0] status_value;

  rghb_avs u_avs (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_read(i_avs_read),
    .i_write(i_avs_write),
    .i_address(i_avs_address),
    .i_byteenable(i_avs_byteenable),
    .i_writedata(i_avs_writedata),
    .i_rd_value(rd_value),
    .o_waitrequest(o_avs_waitrequest),
    .o_readdata(o_avs_readdata),
    .o_index(bus_index),
    .o_wr_strobe(wr_strobe),
    .o_wr_data(wr_data)
  );

  assign wr_gain = wr_strobe & (bus_index == IX_GAIN);
  assign wr_ctrl = wr_strobe & (bus_index == IX_CTRL);
  assign wr_sec1 = wr_strobe & (bus_index == IX_SEC1);
  assign wr_sec2 = wr_strobe & (bus_index == IX_SEC2);
  assign wr_balance = {wr_sec2, wr_sec1, wr_ctrl};

  // registers only change on an accepted write or on reset; nothing else touches them
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      receive_gain_r <= `RGHB_RST_RX_GAIN;
    end else if (wr_gain) begin
      receive_gain_r <= wr_data; // see (R1) (R13)
    end
  end

  // reset value clears the enable so the balance path starts off
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      echo_cancel_control_r <= `RGHB_RST_ECHO_CTRL; // see (R8)
    end else if (wr_ctrl) begin
      echo_cancel_control_r <= wr_data; // see (R13)
    end
  end

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      echo_section_one_setting_r <= `RGHB_RST_SEC1;
    end else if (wr_sec1) begin
      echo_section_one_setting_r <= wr_data; // see (R9) (R13)
    end
  end

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      echo_section_two_setting_r <= `RGHB_RST_SEC2;
    end else if (wr_sec2) begin
      echo_section_two_setting_r <= wr_data; // see (R11) (R13)
    end
  end

  // sticky per-register flags let software see whether setup is complete
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_written
      always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          balance_written_r[gi] <= 1'b0;
        end else if (wr_balance[gi]) begin
          balance_written_r[gi] <= 1'b1; // see (R12)
        end
      end
    end
  endgenerate

  // codes above 11000 have no defined step, so they are held at the deepest one
  assign atten_field = echo_cancel_control_r[`RGHB_ATTEN_MSB:0];
  assign atten_over = atten_field > `RGHB_ATTEN_MAX;
  assign atten_clamped = atten_over ? `RGHB_ATTEN_MAX : atten_field; // see (R7)
  // 24 steps cover 6 dB, a quarter of a decibel each
  assign atten_qdb = `RGHB_ATTEN_BASE_QDB + {3'h0, atten_clamped}; // see (R7)

  assign cancel_on = echo_cancel_control_r[`RGHB_CTRL_EN_BIT]; // see (R4)
  assign sec1_selected = |echo_section_one_setting_r; // see (R9)
  // level relative to the 0 dBm0 code, in tenths of a decibel
  assign level_diff = {1'b0, receive_gain_r} - `RGHB_GAIN_REF_CODE; // see (R1)

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_gain_code <= `RGHB_RST_RX_GAIN;
      o_rx_muted <= 1'b1;
      o_rx_level_tenth_db <= 9'h000;
      o_rx_gain_update <= 1'b0;
    end else begin
      o_rx_gain_code <= receive_gain_r; // see (R1)
      o_rx_muted <= (receive_gain_r == 8'h00);
      o_rx_level_tenth_db <= level_diff;
      o_rx_gain_update <= wr_gain;
    end
  end

  // the analog chain only sees section enables while the path is enabled
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cancel_enable <= 1'b0; // see (R8)
      o_cancel_noninvert <= 1'b0;
      o_high_freq_section_enable <= 1'b0;
      o_cancel_attenuation <= 5'h00;
      o_cancel_atten_quarter_db <= `RGHB_ATTEN_BASE_QDB;
    end else begin
      o_cancel_enable <= cancel_on; // see (R4)
      o_cancel_noninvert <= echo_cancel_control_r[`RGHB_CTRL_NONINV_BIT]; // see (R5)
      o_high_freq_section_enable <= cancel_on &
        echo_cancel_control_r[`RGHB_CTRL_SEC2_BIT]; // see (R6) (R3)
      o_cancel_attenuation <= atten_clamped; // see (R7)
      o_cancel_atten_quarter_db <= atten_qdb;
    end
  end

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_low_freq_section_enable <= 1'b0;
      o_low_freq_biquad <= 1'b0;
      o_low_freq_zero_at_dc <= 1'b0;
      o_low_freq_setting <= 7'h00;
    end else begin
      o_low_freq_section_enable <= cancel_on & sec1_selected; // see (R9) (R3)
      o_low_freq_biquad <= echo_section_one_setting_r[`RGHB_SEC1_MODE_BIT]; // see (R9)
      // first-order mode: single real pole with its zero pinned at dc
      o_low_freq_zero_at_dc <= cancel_on & sec1_selected &
        ~echo_section_one_setting_r[`RGHB_SEC1_MODE_BIT]; // see (R10)
      o_low_freq_setting <= echo_section_one_setting_r[`RGHB_SEC1_SET_MSB:0]; // see (R10)
    end
  end

  // pole and zero fields are separate so one can move without the other
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_high_freq_pole <= 4'h0;
      o_high_freq_zero <= 4'h0;
      o_balance_update <= 1'b0;
    end else begin
      o_high_freq_pole <=
        echo_section_two_setting_r[`RGHB_SEC2_POLE_MSB:`RGHB_SEC2_POLE_LSB]; // see (R11)
      o_high_freq_zero <= echo_section_two_setting_r[`RGHB_SEC2_ZERO_MSB:0]; // see (R11)
      o_balance_update <= |wr_balance;
    end
  end

  always @* begin
    status_value = 8'h00;
    status_value[`RGHB_ST_WRITTEN_LSB +: 3] = balance_written_r; // see (R12)
    status_value[`RGHB_ST_ACTIVE_BIT] = cancel_on;
    status_value[`RGHB_ST_MUTED_BIT] = (receive_gain_r == 8'h00);
    status_value[`RGHB_ST_CLAMP_BIT] = atten_over;
    status_value[`RGHB_ST_SEC1_BIT] = cancel_on & sec1_selected;
    status_value[`RGHB_ST_SEC2_BIT] = cancel_on & echo_cancel_control_r[`RGHB_CTRL_SEC2_BIT];
  end

  // unmapped words read as zero; writes to them are dropped
  always @* begin
    rd_value = 32'h0000_0000;
    case (bus_index)
      IX_GAIN: rd_value[7:0] = receive_gain_r;
      IX_CTRL: rd_value[7:0] = echo_cancel_control_r;
      IX_SEC1: rd_value[7:0] = echo_section_one_setting_r;
      IX_SEC2: rd_value[7:0] = echo_section_two_setting_r;
      IX_STATUS: rd_value[7:0] = status_value;
      IX_LEVEL: begin
        rd_value[8:0] = level_diff;
        rd_value[`RGHB_LVL_ATTEN_LSB +: 8] = atten_qdb;
      end
      IX_INFO: rd_value[7:0] = REVISION;
      default: rd_value = 32'h0000_0000;
    endcase
  end
endmodule

/* verif/rghb_cfg_asserts.sv */
// checker for the gain and echo balance bank
`timescale 1ns/1ps
module rghb_cfg_asserts (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [7:0] i_avs_address,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] i_avs_writedata,
  input wire o_avs_waitrequest,
  input wire [7:0] o_rx_gain_code,
  input wire o_rx_muted,
  input wire signed [8:0] o_rx_level_tenth_db,
  input wire o_cancel_enable,
  input wire o_cancel_noninvert,
  input wire o_high_freq_section_enable,
  input wire [4:0] o_cancel_attenuation,
  input wire [7:0] o_cancel_atten_quarter_db,
  input wire o_low_freq_section_enable,
  input wire o_low_freq_biquad,
  input wire o_low_freq_zero_at_dc,
  input wire [6:0] o_low_freq_setting,
  input wire [3:0] o_high_freq_pole,
  input wire [3:0] o_high_freq_zero
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire [5:0] wix = i_avs_address[7:2];
  reg [7:0] wd_r;
  // last stored byte, so derived outputs can be compared after the write lands
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) wd_r <= 8'h00;
    else if (acc) wd_r <= i_avs_writedata[7:0];
  end
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("no answer one cycle after request");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_gain_store: assert property (acc && wix == 6'h00 |=> ##[0:1]
    o_rx_gain_code == wd_r) else $error("gain code not taken from write");
  // level and code leave reset out of step for one edge, so that edge is skipped
  a_gain_level: assert property ($past(i_rst_b) |->
    o_rx_level_tenth_db == $signed({1'b0, o_rx_gain_code}) - 9'sd174
    && o_rx_muted == (o_rx_gain_code == 8'h00)) else $error("level or mute wrong");
  a_ctrl_fields: assert property (acc && wix == 6'h01 |=> ##[0:1]
    o_cancel_enable == wd_r[7] && o_cancel_noninvert == wd_r[6]
    && o_high_freq_section_enable == (wd_r[7] && wd_r[5])) else $error("control fields wrong");
  a_atten_range: assert property (o_cancel_attenuation <= 5'h18
    && o_cancel_atten_quarter_db == 8'h0A + {3'b000, o_cancel_attenuation})
    else $error("attenuation out of range");
  a_path_gate: assert property (!o_cancel_enable |-> !o_low_freq_section_enable
    && !o_high_freq_section_enable) else $error("section active with path off");
  a_low_bypass: assert property (o_low_freq_section_enable |->
    {o_low_freq_biquad, o_low_freq_setting} != 8'h00) else $error("zero setting not bypassed");
  a_first_order: assert property (o_low_freq_zero_at_dc ==
    (o_low_freq_section_enable && !o_low_freq_biquad)) else $error("dc zero flag wrong");
  a_sec2_place: assert property (acc && wix == 6'h03 |=> ##[0:1]
    {o_high_freq_pole, o_high_freq_zero} == wd_r) else $error("pole or zero wrong");
  a_reset_off: assert property ($rose(i_rst_b) |-> !o_cancel_enable)
    else $error("filter enabled after reset");
  a_hold_value: assert property (o_avs_waitrequest && $past(o_avs_waitrequest)
    && $past(o_avs_waitrequest, 2) |-> $stable(o_rx_gain_code) && $stable(o_cancel_attenuation)
    && $stable(o_low_freq_setting) && $stable(o_high_freq_pole)) else $error("value changed");
endmodule
bind rghb_cfg rghb_cfg_asserts i_chk (.i_clock, .i_rst_b, .i_avs_read, .i_avs_write,
  .i_avs_address, .i_avs_byteenable, .i_avs_writedata, .o_avs_waitrequest, .o_rx_gain_code,
  .o_rx_muted, .o_rx_level_tenth_db, .o_cancel_enable, .o_cancel_noninvert,
  .o_high_freq_section_enable, .o_cancel_attenuation, .o_cancel_atten_quarter_db,
  .o_low_freq_section_enable, .o_low_freq_biquad, .o_low_freq_zero_at_dc,
  .o_low_freq_setting, .o_high_freq_pole, .o_high_freq_zero);

/* verif/rghb_host.sv */
// host model reaching the bank over avalon-mm
`timescale 1ns/1ps
module rghb_host (
  input wire i_clock,
  input wire i_waitrequest,
  input wire [31:0] i_readdata,
  output reg o_read,
  output reg o_write,
  output reg [7:0] o_address,
  output reg [3:0] o_byteenable,
  output reg [31:0] o_writedata
);
  initial begin
    o_read = 1'b0;
    o_write = 1'b0;
    o_address = 8'h00;
    o_byteenable = 4'h0;
    o_writedata = 32'h0;
  end
  // one transfer, held until waitrequest is seen low at a rising edge
  task xfer(input rd, input [7:0] a, input [7:0] d, input [3:0] be, output [31:0] q);
    @(posedge i_clock);
    o_read <= rd;
    o_write <= !rd;
    o_address <= a;
    o_byteenable <= be;
    o_writedata <= {24'h000000, d};
    @(posedge i_clock);
    while (i_waitrequest !== 1'b0) @(posedge i_clock);
    q = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // released lines carry the inverse so stale values never look valid
    o_address <= ~a;
    o_writedata <= ~{24'h000000, d};
  endtask
  // gain code for a wanted output level in volts rms; positive results only
  function [7:0] gain_code(input real v);
    gain_code = $rtoi(200.0 * $log10(v / $sqrt(6.0)) + 174.5);
  endfunction
endmodule

/* verif/rghb_cfg_tb_top.sv */
// testbench top for the gain and echo balance bank
`timescale 1ns/1ps
module rghb_cfg_tb_top;
  reg i_clock = 1'b0;
  reg i_rst_b = 1'b0;
  wire i_avs_read, i_avs_write, o_avs_waitrequest, o_rx_muted, o_rx_gain_update;
  wire o_cancel_enable, o_cancel_noninvert, o_high_freq_section_enable, o_balance_update;
  wire o_low_freq_section_enable, o_low_freq_biquad, o_low_freq_zero_at_dc;
  wire [7:0] i_avs_address, o_rx_gain_code, o_cancel_atten_quarter_db;
  wire [3:0] i_avs_byteenable, o_high_freq_pole, o_high_freq_zero;
  wire [31:0] i_avs_writedata, o_avs_readdata;
  wire signed [8:0] o_rx_level_tenth_db;
  wire [4:0] o_cancel_attenuation;
  wire [6:0] o_low_freq_setting;
  wire [2:0] ctrl_out = {o_cancel_enable, o_cancel_noninvert, o_high_freq_section_enable};
  wire [8:0] low_out = {o_low_freq_section_enable, o_low_freq_zero_at_dc, o_low_freq_setting};
  integer err_total = 0;
  integer n_compared = 0;
  integer i;
  reg [31:0] q;
  always #50 i_clock = ~i_clock;
  rghb_host i_host (.i_clock, .i_waitrequest(o_avs_waitrequest), .i_readdata(o_avs_readdata),
    .o_read(i_avs_read), .o_write(i_avs_write), .o_address(i_avs_address),
    .o_byteenable(i_avs_byteenable), .o_writedata(i_avs_writedata));
  rghb_cfg i_dut (.i_clock, .i_rst_b, .i_avs_read, .i_avs_write, .i_avs_address,
    .i_avs_byteenable, .i_avs_writedata, .o_avs_waitrequest, .o_avs_readdata, .o_rx_gain_code,
    .o_rx_muted, .o_rx_level_tenth_db, .o_rx_gain_update, .o_cancel_enable, .o_cancel_noninvert,
    .o_high_freq_section_enable, .o_cancel_attenuation, .o_cancel_atten_quarter_db,
    .o_low_freq_section_enable, .o_low_freq_biquad, .o_low_freq_zero_at_dc,
    .o_low_freq_setting, .o_high_freq_pole, .o_high_freq_zero, .o_balance_update);
  task chk(input [8*8:1] name, input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input [3:0] be);
    i_host.xfer(1'b0, a, d, be, q);
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    i_host.xfer(1'b1, a, 8'h00, 4'h1, q);
    chk("readback", q, exp);
  endtask
  // derived outputs trail the stored value by a cycle; three edges leave margin
  task settle;
    repeat (3) @(posedge i_clock);
    #1;
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    settle;
    chk("muted", o_rx_muted, 1);
    chk("quarter", o_cancel_atten_quarter_db, 8'h0A);
    chk("enable", o_cancel_enable, 0);
    for (i = 0; i < 4; i = i + 1) rdchk(i * 4, 0);
    rdchk(8'h10, 32'h10);
    $display("reset test done");
    wr(8'h00, i_host.gain_code($sqrt(6.0)), 4'h1);
    settle;
    chk("level", o_rx_level_tenth_db, 9'h000);
    chk("muted", o_rx_muted, 0);
    wr(8'h00, 8'hFF, 4'h1);
    #1;
    chk("gupd", {o_rx_gain_update, o_balance_update}, 2'h2);
    settle;
    chk("level", o_rx_level_tenth_db, 9'h051);
    chk("code", o_rx_gain_code, 8'hFF);
    chk("gupd", o_rx_gain_update, 0);
    $display("gain test done");
    wr(8'h04, 8'hB8, 4'h1);
    #1;
    chk("bupd", {o_rx_gain_update, o_balance_update}, 2'h1);
    wr(8'h08, 8'h05, 4'h1);
    wr(8'h0C, 8'h3C, 4'h1);
    settle;
    chk("ctrl", ctrl_out, 3'h5);
    chk("atten", {o_cancel_attenuation, o_cancel_atten_quarter_db}, 13'h1822);
    chk("low", low_out, 9'h185);
    chk("high", {o_high_freq_pole, o_high_freq_zero}, 8'h3C);
    chk("bupd", o_balance_update, 0);
    rdchk(8'h10, 32'hCF);
    rdchk(8'h14, 32'h0022_0051);
    rdchk(8'h18, 32'h01);
    wr(8'h08, 8'h85, 4'h1);
    settle;
    chk("biquad", {o_low_freq_biquad, o_low_freq_zero_at_dc}, 2'h2);
    wr(8'h08, 8'h00, 4'h1);
    settle;
    chk("bypass", {o_low_freq_section_enable, o_high_freq_section_enable}, 2'h1);
    wr(8'h04, 8'h7F, 4'h1);
    settle;
    chk("ctrl", ctrl_out, 3'h2);
    chk("clamp", o_cancel_attenuation, 5'h18);
    rdchk(8'h04, 32'h7F);
    rdchk(8'h10, 32'h27);
    wr(8'h00, 8'h12, 4'h0);
    wr(8'h1C, 8'h55, 4'h1);
    rdchk(8'h00, 32'hFF);
    rdchk(8'h1C, 32'h0);
    $display("balance test done");
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    settle;
    chk("enable", o_cancel_enable, 0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h10, 32'h10);
    $display("second reset test done");
    stop_test;
  end
endmodule
